// File: pkg/abe_defs.svh
`ifndef ABE_DEFS_SVH
`define ABE_DEFS_SVH
// Summary of operation
// [RL1] add and add-with-carry write sum, set Z C N V H, one cycle
// [RL2] add immediate to word writes pair, sets Z C N V S, two cycles
// [RL3] subtract register or constant, with or without carry, sets Z C N V H
// [RL4] subtract immediate from word writes pair, sets Z C N V S, two cycles
// [RL5] and, or, xor write result, touch only Z N V, one cycle
// [RL6] set bits ors mask, clear bits ands inverted mask, Z N V
// [RL7] test ands register with itself; inc and dec touch Z N V only
// [RL8] multiplies put 16-bit product in R1:R0, set Z C, two cycles
// [RL9] fractional multiplies shift product left one before storing, two cycles
// [RL10] relative jump and call load pc+k+1, two and three cycles
// [RL11] indirect jump and call load pc from Z, two and three cycles
// [RL12] direct jump 3, call 4 cycles; returns reload from stack, interrupt return also sets I, 4 cycles
// [RL13] compare-skip-equal skips next when equal, no flags, 1/2/3 cycles
// [RL14] compares set Z N V C H and write no register, one cycle
// [RL15] register bit skips skip on clear or set bit, no flags
// [RL16] io bit skips skip on clear or set bit, no flags
// [RL17] flag branch takes on set or clear, pc+k+1, 1 or 2 cycles
// [RL18] signed ge and lt branches test N xor V zero or one
// [RL19] unsigned same-higher and lower branch on carry clear or set
// [RL20] named flag branches each take on their flag as named
// [RL21] skip adds two over one-word, three over two-word next, cycles match
// [RL22] flags an instruction does not name keep their previous value

`define ABE_FLAG_C 0
`define ABE_FLAG_Z 1
`define ABE_FLAG_N 2
`define ABE_FLAG_V 3
`define ABE_FLAG_S 4
`define ABE_FLAG_H 5
`define ABE_FLAG_T 6
`define ABE_FLAG_I 7

`define ABE_SREG_RST 8'h00
`define ABE_PC_RST   16'h0000

`define ABE_CYC_1 3'h1
`define ABE_CYC_2 3'h2
`define ABE_CYC_3 3'h3
`define ABE_CYC_4 3'h4
`endif

// File: pkg/abe_pkg.sv
package abe_pkg;
  typedef enum logic [5:0] {
    ABE_NOP, ABE_ADD, ABE_ADD_CARRY, ABE_SUB, ABE_SUBTRACT_WITH_BORROW,
    ABE_AND, ABE_OR, ABE_EXCLUSIVE_OR_OP, ABE_SET_BITS_MASKED, ABE_CLEAR_BITS_MASKED,
    ABE_ZERO_MINUS_TEST, ABE_INC, ABE_DEC, ABE_ADD_IMMEDIATE_WORD,
    ABE_SUBTRACT_IMMEDIATE_WORD, ABE_MUL, ABE_SIGNED_MULTIPLY, ABE_MIXED_SIGN_MULTIPLY,
    ABE_FRACTION_MULTIPLY_UNSIGNED, ABE_FRACTION_MULTIPLY_SIGNED,
    ABE_FRACTION_MULTIPLY_MIXED, ABE_RELATIVE_JUMP, ABE_RELATIVE_CALL,
    ABE_INDIRECT_JUMP, ABE_INDIRECT_CALL, ABE_DIRECT_JUMP, ABE_DIRECT_CALL,
    ABE_RETURN, ABE_INTERRUPT_RETURN, ABE_COMPARE_SKIP_EQUAL, ABE_COMPARE,
    ABE_COMPARE_WITH_BORROW, ABE_SKIP_REG_BIT_CLEAR, ABE_SKIP_REG_BIT_SET,
    ABE_SKIP_IO_BIT_CLEAR, ABE_SKIP_IO_BIT_SET, ABE_BRANCH_FLAG_SET,
    ABE_BRANCH_FLAG_CLEAR, ABE_BRANCH_SIGNED_GE, ABE_BRANCH_SIGNED_LESS
  } abe_op_t;

  typedef enum logic [1:0] {
    ABE_IDLE = 2'b01,
    ABE_EXEC = 2'b10
  } abe_state_t;

  typedef struct packed {
    abe_op_t     op;
    logic [7:0]  a;        // destination or tested register
    logic [7:0]  b;        // source register or immediate
    logic [15:0] word;     // register pair, Z pointer or stack word
    logic [15:0] k;        // sign-extended offset or absolute address
    logic [2:0]  sel;      // bit or flag select
    logic [7:0]  io;       // io register value for bit skips
    logic        two_word; // this instruction is two words long
    logic        next_two; // the following instruction is two words long
  } abe_req_t;

  typedef struct packed {
    logic [15:0] data;     // byte result, word result, product or return address
    logic        wr_byte;
    logic        wr_word;
    logic        wr_pair;  // R1:R0
    logic        push_ret;
  } abe_res_t;
endpackage : abe_pkg

// File: design/abe_core.sv
`timescale 1ns/100ps
`include "abe_defs.svh"
module abe_core (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // request from decode
  input  wire logic             op_valid,
  input  wire abe_pkg::abe_req_t req,
  output logic                  op_ready_ff,
  // result toward register file, pc and status
  output logic                  done_ff,
  output abe_pkg::abe_res_t     res_ff,
  output logic [7:0]            sreg_ff,
  output logic [15:0]           pc_ff
);
  abe_pkg::abe_state_t state_ff;
  abe_pkg::abe_state_t nxt_state;
  logic [2:0]          cnt_ff;
  logic [2:0]          nxt_cnt;
  abe_pkg::abe_res_t   pend_res_ff;
  logic [7:0]          pend_sreg_ff;
  logic [15:0]         pend_pc_ff;
  logic                take;
  logic                exec_done;
  logic [7:0]          sreg_cur;
  logic [15:0]         pc_cur;
  abe_pkg::abe_res_t   c_res;
  logic [7:0]          c_sreg;
  logic [15:0]         c_pc;
  logic [2:0]          c_cyc;
  logic                cin;
  logic [8:0]          add_r;
  logic [8:0]          sub_r;
  logic [7:0]          lg;
  logic [16:0]         wr;
  logic [15:0]         muu;
  logic signed [15:0]  mss;
  logic signed [17:0]  msu;
  logic [15:0]         mp;
  logic [15:0]         len;
  logic                cond;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  assign take      = op_valid && op_ready_ff;
  assign exec_done = (state_ff == abe_pkg::ABE_EXEC) && (cnt_ff == `ABE_CYC_1);
  // operands see a result committing this cycle; ready is low then, so one result per edge
  assign sreg_cur  = exec_done ? pend_sreg_ff : sreg_ff;
  assign pc_cur    = exec_done ? pend_pc_ff : pc_ff;

  always_comb begin
    cin   = sreg_cur[`ABE_FLAG_C] && (req.op == abe_pkg::ABE_ADD_CARRY ||
            req.op == abe_pkg::ABE_SUBTRACT_WITH_BORROW ||
            req.op == abe_pkg::ABE_COMPARE_WITH_BORROW);
    add_r = {1'b0, req.a} + {1'b0, req.b} + {8'h00, cin};
    sub_r = {1'b0, req.a} - {1'b0, req.b} - {8'h00, cin};
    muu   = req.a * req.b;
    mss   = $signed(req.a) * $signed(req.b);
    msu   = $signed({req.a[7], req.a}) * $signed({1'b0, req.b});
    len   = req.two_word ? 16'h0002 : 16'h0001;
  end

  always_comb begin
    c_res = '0;
    c_sreg = sreg_cur; // RL22
    c_pc  = pc_cur + len;
    c_cyc = `ABE_CYC_1;
    lg    = 8'h00;
    wr    = 17'h0_0000;
    mp    = 16'h0000;
    cond  = 1'b0;
    case (req.op)
      abe_pkg::ABE_ADD, abe_pkg::ABE_ADD_CARRY: begin
        c_res.data = {8'h00, add_r[7:0]}; // RL1
        c_res.wr_byte = 1'b1;
        c_sreg[`ABE_FLAG_C] = add_r[8];
        c_sreg[`ABE_FLAG_Z] = (add_r[7:0] == 8'h00);
        c_sreg[`ABE_FLAG_N] = add_r[7];
        c_sreg[`ABE_FLAG_V] = (req.a[7] & req.b[7] & ~add_r[7]) |
                              (~req.a[7] & ~req.b[7] & add_r[7]);
        c_sreg[`ABE_FLAG_H] = (req.a[3] & req.b[3]) | (req.b[3] & ~add_r[3]) |
                              (~add_r[3] & req.a[3]);
      end
      abe_pkg::ABE_SUB, abe_pkg::ABE_SUBTRACT_WITH_BORROW, abe_pkg::ABE_COMPARE,
      abe_pkg::ABE_COMPARE_WITH_BORROW: begin
        c_res.data = {8'h00, sub_r[7:0]}; // RL3
        c_res.wr_byte = (req.op == abe_pkg::ABE_SUB) ||
                        (req.op == abe_pkg::ABE_SUBTRACT_WITH_BORROW); // RL14
        c_sreg[`ABE_FLAG_C] = sub_r[8];
        c_sreg[`ABE_FLAG_Z] = (sub_r[7:0] == 8'h00);
        c_sreg[`ABE_FLAG_N] = sub_r[7];
        c_sreg[`ABE_FLAG_V] = (req.a[7] & ~req.b[7] & ~sub_r[7]) |
                              (~req.a[7] & req.b[7] & sub_r[7]);
        c_sreg[`ABE_FLAG_H] = (~req.a[3] & req.b[3]) | (req.b[3] & sub_r[3]) |
                              (sub_r[3] & ~req.a[3]);
      end
      abe_pkg::ABE_AND, abe_pkg::ABE_OR, abe_pkg::ABE_EXCLUSIVE_OR_OP,
      abe_pkg::ABE_SET_BITS_MASKED, abe_pkg::ABE_CLEAR_BITS_MASKED,
      abe_pkg::ABE_ZERO_MINUS_TEST, abe_pkg::ABE_INC, abe_pkg::ABE_DEC: begin
        case (req.op)
          abe_pkg::ABE_AND:               lg = req.a & req.b; // RL5
          abe_pkg::ABE_OR:                lg = req.a | req.b;
          abe_pkg::ABE_EXCLUSIVE_OR_OP:   lg = req.a ^ req.b;
          abe_pkg::ABE_SET_BITS_MASKED:   lg = req.a | req.b; // RL6
          abe_pkg::ABE_CLEAR_BITS_MASKED: lg = req.a & ~req.b;
          abe_pkg::ABE_INC:               lg = req.a + 8'h01; // RL7
          abe_pkg::ABE_DEC:               lg = req.a - 8'h01;
          default:                        lg = req.a & req.a;
        endcase
        c_res.data = {8'h00, lg};
        c_res.wr_byte = 1'b1;
        c_sreg[`ABE_FLAG_Z] = (lg == 8'h00);
        c_sreg[`ABE_FLAG_N] = lg[7];
        c_sreg[`ABE_FLAG_V] = (req.op == abe_pkg::ABE_INC) ? (lg == 8'h80) :
                              (req.op == abe_pkg::ABE_DEC) ? (lg == 8'h7F) : 1'b0;
      end
      abe_pkg::ABE_ADD_IMMEDIATE_WORD, abe_pkg::ABE_SUBTRACT_IMMEDIATE_WORD: begin
        c_cyc = `ABE_CYC_2; // RL2 RL4
        c_res.wr_word = 1'b1;
        if (req.op == abe_pkg::ABE_ADD_IMMEDIATE_WORD) begin
          wr = {1'b0, req.word} + {9'h000, req.b};
          c_sreg[`ABE_FLAG_V] = ~req.word[15] & wr[15];
          c_sreg[`ABE_FLAG_C] = ~wr[15] & req.word[15];
        end else begin
          wr = {1'b0, req.word} - {9'h000, req.b};
          c_sreg[`ABE_FLAG_V] = req.word[15] & ~wr[15];
          c_sreg[`ABE_FLAG_C] = wr[15] & ~req.word[15];
        end
        c_res.data = wr[15:0];
        c_sreg[`ABE_FLAG_Z] = (wr[15:0] == 16'h0000);
        c_sreg[`ABE_FLAG_N] = wr[15];
        c_sreg[`ABE_FLAG_S] = wr[15] ^ c_sreg[`ABE_FLAG_V];
      end
      abe_pkg::ABE_MUL, abe_pkg::ABE_SIGNED_MULTIPLY, abe_pkg::ABE_MIXED_SIGN_MULTIPLY,
      abe_pkg::ABE_FRACTION_MULTIPLY_UNSIGNED, abe_pkg::ABE_FRACTION_MULTIPLY_SIGNED,
      abe_pkg::ABE_FRACTION_MULTIPLY_MIXED: begin
        c_cyc = `ABE_CYC_2; // RL8
        case (req.op)
          abe_pkg::ABE_MUL, abe_pkg::ABE_FRACTION_MULTIPLY_UNSIGNED: mp = muu;
          abe_pkg::ABE_SIGNED_MULTIPLY, abe_pkg::ABE_FRACTION_MULTIPLY_SIGNED: mp = mss;
          default: mp = msu[15:0];
        endcase
        c_sreg[`ABE_FLAG_C] = mp[15];
        if (req.op == abe_pkg::ABE_FRACTION_MULTIPLY_UNSIGNED ||
            req.op == abe_pkg::ABE_FRACTION_MULTIPLY_SIGNED ||
            req.op == abe_pkg::ABE_FRACTION_MULTIPLY_MIXED) begin
          mp = {mp[14:0], 1'b0}; // RL9
        end
        c_res.data = mp;
        c_res.wr_pair = 1'b1;
        c_sreg[`ABE_FLAG_Z] = (mp == 16'h0000);
      end
      abe_pkg::ABE_RELATIVE_JUMP, abe_pkg::ABE_RELATIVE_CALL: begin
        c_pc = pc_cur + req.k + 16'h0001; // RL10
        c_cyc = (req.op == abe_pkg::ABE_RELATIVE_CALL) ? `ABE_CYC_3 : `ABE_CYC_2;
        c_res.push_ret = (req.op == abe_pkg::ABE_RELATIVE_CALL);
        c_res.data = pc_cur + len;
      end
      abe_pkg::ABE_INDIRECT_JUMP, abe_pkg::ABE_INDIRECT_CALL: begin
        c_pc = req.word; // RL11
        c_cyc = (req.op == abe_pkg::ABE_INDIRECT_CALL) ? `ABE_CYC_3 : `ABE_CYC_2;
        c_res.push_ret = (req.op == abe_pkg::ABE_INDIRECT_CALL);
        c_res.data = pc_cur + len;
      end
      abe_pkg::ABE_DIRECT_JUMP, abe_pkg::ABE_DIRECT_CALL: begin
        c_pc = req.k; // RL12
        c_cyc = (req.op == abe_pkg::ABE_DIRECT_CALL) ? `ABE_CYC_4 : `ABE_CYC_3;
        c_res.push_ret = (req.op == abe_pkg::ABE_DIRECT_CALL);
        c_res.data = pc_cur + len;
      end
      abe_pkg::ABE_RETURN, abe_pkg::ABE_INTERRUPT_RETURN: begin
        c_pc = req.word; // RL12
        c_cyc = `ABE_CYC_4;
        if (req.op == abe_pkg::ABE_INTERRUPT_RETURN) begin
          c_sreg[`ABE_FLAG_I] = 1'b1;
        end
      end
      abe_pkg::ABE_COMPARE_SKIP_EQUAL, abe_pkg::ABE_SKIP_REG_BIT_CLEAR,
      abe_pkg::ABE_SKIP_REG_BIT_SET, abe_pkg::ABE_SKIP_IO_BIT_CLEAR,
      abe_pkg::ABE_SKIP_IO_BIT_SET: begin
        case (req.op)
          abe_pkg::ABE_COMPARE_SKIP_EQUAL: cond = (req.a == req.b); // RL13
          abe_pkg::ABE_SKIP_REG_BIT_CLEAR: cond = ~req.a[req.sel]; // RL15
          abe_pkg::ABE_SKIP_REG_BIT_SET:   cond = req.a[req.sel];
          abe_pkg::ABE_SKIP_IO_BIT_CLEAR:  cond = ~req.io[req.sel]; // RL16
          default:                         cond = req.io[req.sel];
        endcase
        if (cond) begin
          c_pc  = pc_cur + (req.next_two ? 16'h0003 : 16'h0002); // RL21
          c_cyc = req.next_two ? `ABE_CYC_3 : `ABE_CYC_2;
        end
      end
      abe_pkg::ABE_BRANCH_FLAG_SET, abe_pkg::ABE_BRANCH_FLAG_CLEAR,
      abe_pkg::ABE_BRANCH_SIGNED_GE, abe_pkg::ABE_BRANCH_SIGNED_LESS: begin
        case (req.op)
          abe_pkg::ABE_BRANCH_FLAG_SET:   cond = sreg_cur[req.sel]; // RL17 RL19 RL20
          abe_pkg::ABE_BRANCH_FLAG_CLEAR: cond = ~sreg_cur[req.sel];
          abe_pkg::ABE_BRANCH_SIGNED_GE:  cond = ~(sreg_cur[`ABE_FLAG_N] ^
                                                   sreg_cur[`ABE_FLAG_V]); // RL18
          default:                        cond = sreg_cur[`ABE_FLAG_N] ^ sreg_cur[`ABE_FLAG_V];
        endcase
        if (cond) begin
          c_pc  = pc_cur + req.k + 16'h0001;
          c_cyc = `ABE_CYC_2;
        end
      end
      default: begin
        c_cyc = `ABE_CYC_1;
      end
    endcase
  end

  // sequencing: one-cycle ops commit at take, longer ops wait in exec
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      abe_pkg::ABE_IDLE: begin
        nxt_state = abe_pkg::ABE_IDLE;
      end
      abe_pkg::ABE_EXEC: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff == `ABE_CYC_1) begin
          nxt_state = abe_pkg::ABE_IDLE;
        end
      end
      default: begin
        nxt_state = abe_pkg::ABE_IDLE;
      end
    endcase
    if (take && c_cyc != `ABE_CYC_1) begin
      nxt_state = abe_pkg::ABE_EXEC;
      nxt_cnt   = c_cyc - 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= abe_pkg::ABE_IDLE;
      cnt_ff      <= 3'h0;
      op_ready_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      // low through exec: a one-cycle op taken on the commit edge would drop a result
      op_ready_ff <= (nxt_state == abe_pkg::ABE_IDLE);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_res_ff  <= '0;
      pend_sreg_ff <= `ABE_SREG_RST;
      pend_pc_ff   <= `ABE_PC_RST;
    end else if (take) begin
      pend_res_ff  <= c_res;
      pend_sreg_ff <= c_sreg;
      pend_pc_ff   <= c_pc;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      res_ff  <= '0;
      sreg_ff <= `ABE_SREG_RST;
      pc_ff   <= `ABE_PC_RST;
    end else if (take && c_cyc == `ABE_CYC_1) begin
      done_ff <= 1'b1;
      res_ff  <= c_res;
      sreg_ff <= c_sreg;
      pc_ff   <= c_pc;
    end else if (exec_done) begin
      done_ff <= 1'b1;
      res_ff  <= pend_res_ff;
      sreg_ff <= pend_sreg_ff;
      pc_ff   <= pend_pc_ff;
    end else begin
      done_ff <= 1'b0;
      res_ff  <= '0;
    end
  end

  sequence s_two_cyc;
    !done_ff ##1 done_ff;
  endsequence
  sequence s_four_cyc;
    !done_ff [*3] ##1 done_ff;
  endsequence

  add_sum_a: assert property ((take && req.op == abe_pkg::ABE_ADD) |=> // RL1
    done_ff && res_ff.data[7:0] == 8'($past(req.a) + $past(req.b)))
    else $error("add sum wrong");
  word_time_a: assert property ((take && req.op == abe_pkg::ABE_ADD_IMMEDIATE_WORD) // RL2
    |=> s_two_cyc) else $error("word add not two cycles");
  mul_pair_a: assert property ((take && req.op == abe_pkg::ABE_MUL) |=> s_two_cyc // RL8
    ##0 (res_ff.wr_pair && res_ff.data == $past(req.a, 2) * $past(req.b, 2)))
    else $error("multiply product wrong");
  fraction_multiply_unsigned_shift_a: assert property ((take && req.op == abe_pkg::ABE_FRACTION_MULTIPLY_UNSIGNED) // RL9
    |-> ##2 (done_ff && !res_ff.data[0])) else $error("fraction product not shifted");
  logic_v_a: assert property ((take && (req.op == abe_pkg::ABE_AND || // RL5
    req.op == abe_pkg::ABE_EXCLUSIVE_OR_OP)) |=> !sreg_ff[`ABE_FLAG_V])
    else $error("logic op left V set");
  call_time_a: assert property ((take && req.op == abe_pkg::ABE_DIRECT_CALL) // RL12
    |=> s_four_cyc ##0 res_ff.push_ret) else $error("direct call not four cycles");
  skip_pc_a: assert property ((take && req.op == abe_pkg::ABE_COMPARE_SKIP_EQUAL && // RL21
    req.a == req.b && !req.next_two) |-> ##2 (done_ff && pc_ff == $past(pc_cur, 2) + 16'h0002))
    else $error("skip did not add two");
  branch_nt_a: assert property ((take && req.op == abe_pkg::ABE_BRANCH_FLAG_SET && // RL17
    !sreg_cur[req.sel] && !req.two_word) |=> (done_ff && pc_ff == $past(pc_cur) + 16'h0001))
    else $error("untaken branch wrong");
  cmp_nowrite_a: assert property ((take && req.op == abe_pkg::ABE_COMPARE) // RL14
    |=> (done_ff && !res_ff.wr_byte)) else $error("compare wrote a register");
  keep_t_a: assert property ((take && req.op == abe_pkg::ABE_ADD) // RL22
    |=> sreg_ff[`ABE_FLAG_T] == $past(sreg_cur[`ABE_FLAG_T])) else $error("T flag changed");
  sub_diff_a: assert property ((take && req.op == abe_pkg::ABE_SUB) |=> // RL3
    done_ff && res_ff.data[7:0] == 8'($past(req.a) - $past(req.b)))
    else $error("subtract difference wrong");
  word_sub_a: assert property ((take && req.op == abe_pkg::ABE_SUBTRACT_IMMEDIATE_WORD) // RL4
    |=> s_two_cyc) else $error("word subtract not two cycles");
  set_bits_a: assert property ((take && req.op == abe_pkg::ABE_SET_BITS_MASKED) |=> // RL6
    res_ff.data[7:0] == ($past(req.a) | $past(req.b))) else $error("bit set result wrong");
  test_keep_a: assert property ((take && req.op == abe_pkg::ABE_ZERO_MINUS_TEST) |=> // RL7
    res_ff.data[7:0] == $past(req.a)) else $error("test changed the register");
  rel_jump_a: assert property ((take && req.op == abe_pkg::ABE_RELATIVE_JUMP) |-> ##2 // RL10
    (done_ff && pc_ff == $past(pc_cur, 2) + $past(req.k, 2) + 16'h0001))
    else $error("relative jump target wrong");
  ind_jump_a: assert property ((take && req.op == abe_pkg::ABE_INDIRECT_JUMP) |-> ##2 // RL11
    (done_ff && pc_ff == $past(req.word, 2))) else $error("indirect jump target wrong");
  skip_flags_a: assert property ((take && req.op == abe_pkg::ABE_COMPARE_SKIP_EQUAL) |=> // RL13
    sreg_ff == $past(sreg_cur)) else $error("compare skip changed flags");
  ge_branch_a: assert property ((take && req.op == abe_pkg::ABE_BRANCH_SIGNED_GE && // RL18
    !(sreg_cur[`ABE_FLAG_N] ^ sreg_cur[`ABE_FLAG_V])) |-> ##2
    (done_ff && pc_ff == $past(pc_cur, 2) + $past(req.k, 2) + 16'h0001))
    else $error("signed branch not taken");
  bit_skip_a: assert property ((take && req.op == abe_pkg::ABE_SKIP_REG_BIT_CLEAR && // RL15
    !req.a[req.sel] && !req.next_two) |-> ##2 (done_ff && pc_ff == $past(pc_cur, 2) + 16'h0002))
    else $error("register bit skip wrong");
  io_skip_a: assert property ((take && req.op == abe_pkg::ABE_SKIP_IO_BIT_SET && // RL16
    req.io[req.sel] && req.next_two) |-> ##3 (done_ff && pc_ff == $past(pc_cur, 3) + 16'h0003))
    else $error("io bit skip wrong");
  ready_busy_a: assert property ((state_ff == abe_pkg::ABE_EXEC) |-> !op_ready_ff) // RL12
    else $error("ready high during execution");
endmodule : abe_core

// File: tb/abe_dec_model.sv
`timescale 1ns/100ps
module abe_dec_model (
  // clock
  input  wire logic         sys_clk,
  // handshake with the core
  input  wire logic         op_ready_ff,
  output logic              op_valid,
  output abe_pkg::abe_req_t req
);
  initial begin
    op_valid = 1'b0;
    req      = '0;
  end

  // offer just after an edge, hold until an edge sees ready high
  task automatic issue(input abe_pkg::abe_req_t r);
    op_valid = 1'b1;
    req      = r;
    while (op_ready_ff !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1;
    op_valid = 1'b0;
    // a released request bus shows the inverse, never the stale value
    req      = abe_pkg::abe_req_t'(~r);
  endtask : issue
endmodule : abe_dec_model

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  // clock and reset
  logic              sys_clk;
  logic              rst_n;
  // request and result
  logic              op_valid;
  abe_pkg::abe_req_t req;
  logic              op_ready_ff;
  logic              done_ff;
  abe_pkg::abe_res_t res_ff;
  logic [7:0]        sreg_ff;
  logic [15:0]       pc_ff;
  // expectations and counters
  logic [7:0]        sr_e;
  logic [15:0]       pc_e;
  int                n_fail;
  int                check_count;

  abe_core uut (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .op_valid    (op_valid),
    .req         (req),
    .op_ready_ff (op_ready_ff),
    .done_ff     (done_ff),
    .res_ff      (res_ff),
    .sreg_ff     (sreg_ff),
    .pc_ff       (pc_ff)
  );

  abe_dec_model dec (
    .sys_clk     (sys_clk),
    .op_ready_ff (op_ready_ff),
    .op_valid    (op_valid),
    .req         (req)
  );

  always #12.5 sys_clk = ~sys_clk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one operation: offer, count cycles to completion, compare writes, sreg, pc and data when written
  task automatic run(input abe_pkg::abe_op_t op, input logic [7:0] a, b,
                     input logic [15:0] w, k, input logic [2:0] sel, input logic nt,
                     input logic [15:0] ed, input logic [3:0] ewr, input logic [7:0] es,
                     input logic [15:0] ep, input int ec);
    abe_pkg::abe_req_t r;
    int                n;
    r = '{op, a, b, w, k, sel, ~a, 1'b0, nt};
    r.two_word = (op == abe_pkg::ABE_DIRECT_JUMP) || (op == abe_pkg::ABE_DIRECT_CALL);
    dec.issue(r);
    n = 1;
    while (done_ff !== 1'b1 && n < 9) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("cycles", 16'(n), 16'(ec));
    chk("writes", {res_ff.wr_byte, res_ff.wr_word, res_ff.wr_pair, res_ff.push_ret}, ewr);
    if (ewr != 4'h0)
      chk("data", res_ff.data, ed);
    chk("sreg", sreg_ff, es);
    chk("pc", pc_ff, ep);
    sr_e = es;
    pc_e = ep;
    @(posedge sys_clk);
    #1;
    chk("done pulse", done_ff, 1'b0);
  endtask : run

  task automatic alu(input abe_pkg::abe_op_t op, input logic [7:0] a, b, ed, es);
    logic [3:0] wr;
    wr = (op == abe_pkg::ABE_COMPARE || op == abe_pkg::ABE_COMPARE_WITH_BORROW) ? 4'h0 : 4'h8;
    run(op, a, b, '0, '0, '0, '0, {8'h00, ed}, wr, es, pc_e + 16'h1, 1);
  endtask : alu

  task automatic two_cyc(input abe_pkg::abe_op_t op, input logic [7:0] a, b,
                         input logic [15:0] w, ed, input logic [3:0] ewr, input logic [7:0] es);
    run(op, a, b, w, '0, '0, '0, ed, ewr, es, pc_e + 16'h1, 2);
  endtask : two_cyc

  task automatic br(input abe_pkg::abe_op_t op, input logic [2:0] s, input logic [15:0] k,
                    input logic tk);
    run(op, '0, '0, '0, k, s, '0, '0, 4'h0, sr_e, tk ? pc_e + k + 16'h1 : pc_e + 16'h1, tk ? 2 : 1);
  endtask : br

  task automatic jp(input abe_pkg::abe_op_t op, input logic [15:0] w, k, ed,
                    input logic [3:0] ewr, input logic [7:0] es, input logic [15:0] ep,
                    input int ec);
    run(op, '0, '0, w, k, '0, '0, ed, ewr, es, ep, ec);
  endtask : jp

  task automatic sk(input abe_pkg::abe_op_t op, input logic [7:0] a, b, input logic [2:0] s,
                    input logic nt, tk);
    int c;
    c = tk ? (nt ? 3 : 2) : 1;
    run(op, a, b, '0, '0, s, nt, '0, 4'h0, sr_e, pc_e + 16'(c), c);
  endtask : sk

  initial begin
    #50000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    sys_clk     = 1'b0;
    rst_n       = 1'b0;
    n_fail      = 0;
    check_count = 0;
    sr_e        = '0;
    pc_e        = '0;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("ready", op_ready_ff, 1'b1);
    chk("reset sreg", sreg_ff, '0);
    chk("reset pc", pc_ff, '0);
    two_cyc(abe_pkg::ABE_ADD_IMMEDIATE_WORD, '0, 8'h01, 16'hffff, 16'h0000, 4'h4, 8'h03);
    two_cyc(abe_pkg::ABE_SUBTRACT_IMMEDIATE_WORD, '0, 8'h01, '0, 16'hffff, 4'h4, 8'h15);
    alu(abe_pkg::ABE_ADD, 8'h08, 8'h08, 8'h10, 8'h30);
    alu(abe_pkg::ABE_ADD, 8'h80, 8'h80, 8'h00, 8'h1b);
    alu(abe_pkg::ABE_ADD_CARRY, 8'h01, 8'h01, 8'h03, 8'h10);
    alu(abe_pkg::ABE_SUB, 8'h00, 8'h01, 8'hff, 8'h35);
    alu(abe_pkg::ABE_AND, 8'hf0, 8'h0f, 8'h00, 8'h33);
    alu(abe_pkg::ABE_SUBTRACT_WITH_BORROW, 8'h05, 8'h04, 8'h00, 8'h12);
    alu(abe_pkg::ABE_OR, 8'h80, 8'h01, 8'h81, 8'h14);
    alu(abe_pkg::ABE_EXCLUSIVE_OR_OP, 8'hff, 8'h0f, 8'hf0, 8'h14);
    alu(abe_pkg::ABE_SET_BITS_MASKED, 8'h01, 8'h40, 8'h41, 8'h10);
    alu(abe_pkg::ABE_ZERO_MINUS_TEST, 8'h80, 8'h00, 8'h80, 8'h14);
    alu(abe_pkg::ABE_CLEAR_BITS_MASKED, 8'h01, 8'h01, 8'h00, 8'h12);
    alu(abe_pkg::ABE_INC, 8'h7f, 8'h00, 8'h80, 8'h1c);
    alu(abe_pkg::ABE_DEC, 8'h01, 8'h00, 8'h00, 8'h12);
    alu(abe_pkg::ABE_COMPARE, 8'h10, 8'h20, 8'h00, 8'h15);
    alu(abe_pkg::ABE_COMPARE_WITH_BORROW, 8'h20, 8'h1f, 8'h00, 8'h32);
    two_cyc(abe_pkg::ABE_MUL, 8'hff, 8'hff, '0, 16'hfe01, 4'h2, 8'h31);
    two_cyc(abe_pkg::ABE_SIGNED_MULTIPLY, 8'hff, 8'h02, '0, 16'hfffe, 4'h2, 8'h31);
    two_cyc(abe_pkg::ABE_MIXED_SIGN_MULTIPLY, 8'hff, 8'hff, '0, 16'hff01, 4'h2, 8'h31);
    two_cyc(abe_pkg::ABE_FRACTION_MULTIPLY_UNSIGNED, 8'h80, 8'h80, '0, 16'h8000, 4'h2, 8'h30);
    two_cyc(abe_pkg::ABE_FRACTION_MULTIPLY_SIGNED, 8'hc0, 8'h40, '0, 16'he000, 4'h2, 8'h31);
    two_cyc(abe_pkg::ABE_FRACTION_MULTIPLY_MIXED, 8'h00, 8'h55, '0, 16'h0000, 4'h2, 8'h32);
    br(abe_pkg::ABE_BRANCH_FLAG_SET, 3'h1, 16'h0010, 1'b1);
    br(abe_pkg::ABE_BRANCH_FLAG_CLEAR, 3'h1, 16'h0010, 1'b0);
    br(abe_pkg::ABE_BRANCH_FLAG_SET, 3'h0, 16'h0010, 1'b0);
    br(abe_pkg::ABE_BRANCH_FLAG_CLEAR, 3'h0, 16'hfff0, 1'b1);
    br(abe_pkg::ABE_BRANCH_SIGNED_GE, 3'h0, 16'h0004, 1'b1);
    br(abe_pkg::ABE_BRANCH_SIGNED_LESS, 3'h0, 16'h0004, 1'b0);
    jp(abe_pkg::ABE_RELATIVE_JUMP, '0, 16'hfffe, '0, 4'h0, sr_e, pc_e - 16'h1, 2);
    jp(abe_pkg::ABE_RELATIVE_CALL, '0, 16'h0005, pc_e + 16'h1, 4'h1, sr_e, pc_e + 16'h6, 3);
    jp(abe_pkg::ABE_INDIRECT_JUMP, 16'h1234, '0, '0, 4'h0, sr_e, 16'h1234, 2);
    jp(abe_pkg::ABE_INDIRECT_CALL, 16'h0400, '0, pc_e + 16'h1, 4'h1, sr_e, 16'h0400, 3);
    jp(abe_pkg::ABE_DIRECT_JUMP, '0, 16'h0200, '0, 4'h0, sr_e, 16'h0200, 3);
    jp(abe_pkg::ABE_DIRECT_CALL, '0, 16'h0300, pc_e + 16'h2, 4'h1, sr_e, 16'h0300, 4);
    jp(abe_pkg::ABE_RETURN, 16'h0202, '0, '0, 4'h0, sr_e, 16'h0202, 4);
    jp(abe_pkg::ABE_INTERRUPT_RETURN, 16'h0204, '0, '0, 4'h0, 8'hb2, 16'h0204, 4);
    sk(abe_pkg::ABE_COMPARE_SKIP_EQUAL, 8'h05, 8'h05, 3'h0, 1'b0, 1'b1);
    sk(abe_pkg::ABE_COMPARE_SKIP_EQUAL, 8'h05, 8'h05, 3'h0, 1'b1, 1'b1);
    sk(abe_pkg::ABE_COMPARE_SKIP_EQUAL, 8'h05, 8'h06, 3'h0, 1'b1, 1'b0);
    sk(abe_pkg::ABE_SKIP_REG_BIT_CLEAR, 8'hfb, 8'h00, 3'h2, 1'b0, 1'b1);
    sk(abe_pkg::ABE_SKIP_REG_BIT_SET, 8'hfb, 8'h00, 3'h2, 1'b1, 1'b0);
    sk(abe_pkg::ABE_SKIP_IO_BIT_SET, 8'h7f, 8'h00, 3'h7, 1'b1, 1'b1);
    sk(abe_pkg::ABE_SKIP_IO_BIT_CLEAR, 8'h7f, 8'h00, 3'h7, 1'b0, 1'b0);
    alu(abe_pkg::ABE_COMPARE, 8'h10, 8'h20, 8'h00, 8'h95);
    br(abe_pkg::ABE_BRANCH_SIGNED_LESS, 3'h0, 16'h0004, 1'b1);
    for (int i = 0; i < 8; i++) begin
      br(abe_pkg::ABE_BRANCH_FLAG_SET, 3'(i), 16'h0002, sr_e[i]);
      br(abe_pkg::ABE_BRANCH_FLAG_CLEAR, 3'(i), 16'h0002, !sr_e[i]);
    end
    // reset in mid-run clears state at once
    rst_n = 1'b0;
    #1;
    chk("reset pc", pc_ff, '0);
    chk("reset sreg", sreg_ff, '0);
    chk("reset ready", op_ready_ff, 1'b0);
    @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("ready", op_ready_ff, 1'b1);
    sr_e = '0;
    pc_e = '0;
    alu(abe_pkg::ABE_ADD, 8'h01, 8'h02, 8'h03, 8'h00);
    tally_and_finish();
  end
endmodule : tb
